/* File: core/fswc_top.sv */
// fswc_top: fpu status, control and tag words with apb access
`timescale 1ns/10ps
// Operation
// - condition codes zeroed: init, incomplete remainder, reset
// - status bit 10 flags incomplete tangent
// - control bit 12 stored, never affects arithmetic
// - stack fault sets invalid and stack flags
// - status bit 9 tells overflow from underflow
// - numeric invalid leaves stack fault flag alone
// - loaded tag 11 empty, others nonempty
// - operand class comes from register contents
// - stored tag word recomputed from register contents
module fswc_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                instr_valid,
  input  wire fswc_pkg::fswc_instr_t instr,
  output logic                     instr_done,
  output logic      [15:0]         tag_word_out,
  output logic      [15:0]         arith_ctrl,
  output logic                     irq
);
  // stack slot helpers
  function automatic logic [2:0] fswc_phys(input logic [2:0] t,
                                           input logic [2:0] i);
    return 3'(t + i);
  endfunction

  // tag word from empty marks and content classes
  function automatic logic [15:0] fswc_tags(input logic [7:0] emp,
                                            input logic [15:0] cl);
    logic [15:0] tw;
    tw = '0;
    for (int k = 0; k < 8; k++)
      tw[2*k +: 2] = emp[k] ? fswc_pkg::TAG_EMPTY : cl[2*k +: 2];
    return tw;
  endfunction

  // empty marks taken from a loaded tag word
  function automatic logic [7:0] fswc_ld_empty(input logic [15:0] tw);
    logic [7:0] e;
    e = '0;
    for (int k = 0; k < 8; k++)
      e[k] = (tw[2*k +: 2] == fswc_pkg::TAG_EMPTY);
    return e;
  endfunction

  logic [15:0] sw;        // status word without the top field
  logic [2:0]  top;       // stack top pointer
  logic [15:0] cw;        // control word as written
  logic [7:0]  empty;     // per physical register empty mark
  logic [15:0] cls;       // per register class from contents
  logic [1:0]  cls_in;    // class of the incoming value
  logic        go;        // instruction accepted this cycle
  logic [2:0]  push_slot; // slot a push would fill
  logic [2:0]  rd_slot;   // slot addressed by st(idx)
  logic        ovf;       // push onto a nonempty slot
  logic        unf;       // pop or read of an empty slot
  logic        sfault;    // either stack fault
  logic        numinv;    // numeric invalid operation
  logic        ptan_inc;  // tangent reduction incomplete
  logic [15:0] status_now;
  logic        apb_setup;
  logic        apb_wr;
  // event count comes from the package so the map and the bank agree
  localparam int IRQ_WIDTH = fswc_pkg::IRQ_W;
  logic [IRQ_WIDTH-1:0] irq_sts;
  logic [IRQ_WIDTH-1:0] irq_en;
  logic [IRQ_WIDTH-1:0] irq_evt;
  logic        irq_q;     // registered interrupt level

  fswc_classify u_cls (
    .value (instr.value),
    .cls   (cls_in)
  );

  // decode of the present instruction
  assign go        = instr_valid;
  assign push_slot = 3'(top - 3'h1);
  assign rd_slot   = fswc_phys(top, instr.idx);
  assign ovf       = go && instr.op == fswc_pkg::OP_PUSH
                     && !empty[push_slot];
  assign unf       = go && ((instr.op == fswc_pkg::OP_POP && empty[top])
                     || (instr.op == fswc_pkg::OP_READ
                         && empty[rd_slot]));
  assign sfault    = ovf || unf;
  assign numinv    = go && instr.op == fswc_pkg::OP_NUMINV;
  assign ptan_inc  = go && instr.op == fswc_pkg::OP_PTAN
                     && instr.arg[fswc_pkg::ARG_INC];
  assign status_now = sw | {2'h0, top, 11'h000};

  // status word: condition codes and exception flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw <= fswc_pkg::SW_RST;
    end else if (go) begin
      case (instr.op)
        fswc_pkg::OP_INIT: begin
          sw <= fswc_pkg::SW_RST;
        end
        fswc_pkg::OP_PREM: begin
          sw[fswc_pkg::SW_C2] <= 1'b0;
          if (instr.arg[fswc_pkg::ARG_INC]) begin
            // unfinished reduction leaves no stale quotient bits
            sw[fswc_pkg::SW_C0] <= 1'b0;
            sw[fswc_pkg::SW_C1] <= 1'b0;
            sw[fswc_pkg::SW_C3] <= 1'b0;
          end else begin
            sw[fswc_pkg::SW_C0] <= instr.arg[2];
            sw[fswc_pkg::SW_C3] <= instr.arg[1];
            sw[fswc_pkg::SW_C1] <= instr.arg[0];
          end
        end
        fswc_pkg::OP_PTAN: begin
          // lets software test the operand range quickly
          sw[fswc_pkg::SW_C2] <= instr.arg[fswc_pkg::ARG_INC];
        end
        fswc_pkg::OP_NUMINV: begin
          sw[fswc_pkg::SW_IE] <= 1'b1;
        end
        fswc_pkg::OP_CLREX: begin
          sw[7:0] <= 8'h00; // exception flags only
        end
        default: begin
          // stack ops handled below
        end
      endcase
      if (sfault) begin
        sw[fswc_pkg::SW_IE] <= 1'b1;
        sw[fswc_pkg::SW_SF] <= 1'b1;
        sw[fswc_pkg::SW_C1] <= ovf;
      end
    end
  end

  // stack top pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top <= 3'h0;
    end else if (go) begin
      case (instr.op)
        fswc_pkg::OP_INIT: top <= 3'h0;
        fswc_pkg::OP_PUSH: if (!ovf) top <= push_slot;
        fswc_pkg::OP_POP:  if (!unf) top <= 3'(top + 3'h1);
        default:           top <= top;
      endcase
    end
  end

  // empty marks and content classes per physical register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty <= 8'hFF;
      cls   <= 16'h0000;
    end else if (go) begin
      case (instr.op)
        fswc_pkg::OP_INIT: empty <= 8'hFF;
        fswc_pkg::OP_PUSH: begin
          if (!ovf) begin
            empty[push_slot]      <= 1'b0;
            cls[2*push_slot +: 2] <= cls_in;
          end
        end
        fswc_pkg::OP_POP: if (!unf) empty[top] <= 1'b1;
        fswc_pkg::OP_WRREG: begin
          // restored contents are classified as written
          empty[rd_slot]      <= 1'b0;
          cls[2*rd_slot +: 2] <= cls_in;
        end
        fswc_pkg::OP_LDENV, fswc_pkg::OP_RSTOR: begin
          // loaded class codes are dropped, only emptiness kept
          empty <= fswc_ld_empty(instr.arg);
        end
        default: empty <= empty;
      endcase
    end
  end

  // tag word written out by store and save
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_word_out <= 16'hFFFF;
    end else if (go && (instr.op == fswc_pkg::OP_STENV
                     || instr.op == fswc_pkg::OP_SAVE)) begin
      tag_word_out <= fswc_tags(empty, cls);
    end
  end

  // one-cycle completion pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) instr_done <= 1'b0;
    else          instr_done <= go;
  end

  // control word; init restores the default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw <= fswc_pkg::CW_RST;
    end else if (go && instr.op == fswc_pkg::OP_INIT) begin
      cw <= fswc_pkg::CW_RST;
    end else if (apb_wr && paddr == fswc_pkg::OFF_CONTROL) begin
      cw <= pwdata[15:0];
    end
  end

  // datapath copy; closure bit masked so only affine arithmetic exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arith_ctrl <= fswc_pkg::CW_RST & ~(16'h0001 << fswc_pkg::CW_INF);
    end else begin
      arith_ctrl <= cw & ~(16'h0001 << fswc_pkg::CW_INF);
    end
  end

  // interrupt events
  always_comb begin
    irq_evt = '0;
    irq_evt[fswc_pkg::IRQ_SF]   = sfault;
    irq_evt[fswc_pkg::IRQ_NUM]  = numinv;
    irq_evt[fswc_pkg::IRQ_PTAN] = ptan_inc;
  end

  fswc_irq #(
    .W (IRQ_WIDTH)
  ) u_irq (
    .clk    (pclk),
    .rst_n  (presetn),
    .evt    (irq_evt),
    .en_we  (apb_wr && paddr == fswc_pkg::OFF_IRQ_EN),
    .en_wd  (pwdata[IRQ_WIDTH-1:0]),
    .clr_we (apb_wr && paddr == fswc_pkg::OFF_IRQ_CLR),
    .clr_wd (pwdata[IRQ_WIDTH-1:0]),
    .sts    (irq_sts),
    .en     (irq_en),
    .irq    (irq_q)
  );
  assign irq = irq_q;

  // apb: data and error captured in setup, answer in first access cycle
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr)
          fswc_pkg::OFF_STATUS:  if (!pwrite) prdata <= {16'h0000, status_now};
          fswc_pkg::OFF_CONTROL: if (!pwrite) prdata <= {16'h0000, cw};
          fswc_pkg::OFF_TAG: begin
            if (!pwrite) prdata <= {16'h0000, tag_word_out};
          end
          fswc_pkg::OFF_IRQ_STS: if (!pwrite) prdata <= 32'(irq_sts);
          fswc_pkg::OFF_IRQ_EN:  if (!pwrite) prdata <= 32'(irq_en);
          fswc_pkg::OFF_IRQ_CLR: prdata <= 32'h0000_0000; // reads zero
          default:               pslverr <= 1'b1; // unmapped
        endcase
      end
    end
  end

  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [2:0] cc_slot; // helper: physical slot a write hit
  assign cc_slot = rd_slot;

  AST_INIT_CC: assert property (
    go && instr.op == fswc_pkg::OP_INIT |=> status_now == 16'h0000)
    else $error("init left status bits set");
  AST_PREM_CC: assert property (
    go && instr.op == fswc_pkg::OP_PREM && instr.arg[fswc_pkg::ARG_INC]
    |=> !sw[fswc_pkg::SW_C0] && !sw[fswc_pkg::SW_C1]
        && !sw[fswc_pkg::SW_C2] && !sw[fswc_pkg::SW_C3])
    else $error("incomplete remainder kept condition codes");
  AST_PTAN_C2: assert property (
    go && instr.op == fswc_pkg::OP_PTAN
    |=> sw[fswc_pkg::SW_C2] == $past(instr.arg[fswc_pkg::ARG_INC]))
    else $error("tangent incomplete bit wrong");
  AST_AFFINE: assert property (
    !arith_ctrl[fswc_pkg::CW_INF]
    && (arith_ctrl[11:0] == $past(cw[11:0])))
    else $error("closure bit reached datapath");
  AST_SF_SET: assert property (
    sfault |=> sw[fswc_pkg::SW_IE] && sw[fswc_pkg::SW_SF] && irq_sts[0])
    else $error("stack fault flags not set");
  AST_SF_DIR: assert property (
    sfault |=> sw[fswc_pkg::SW_C1] == $past(ovf))
    else $error("overflow direction bit wrong");
  AST_NUM_NOSF: assert property (
    numinv |=> sw[fswc_pkg::SW_IE]
               && sw[fswc_pkg::SW_SF] == $past(sw[fswc_pkg::SW_SF]))
    else $error("numeric invalid touched stack fault");
  AST_LD_TAGS: assert property (
    go && (instr.op == fswc_pkg::OP_LDENV || instr.op == fswc_pkg::OP_RSTOR)
    |=> empty == fswc_ld_empty($past(instr.arg)))
    else $error("loaded tags misread");
  AST_WR_CLASS: assert property (
    go && instr.op == fswc_pkg::OP_WRREG
    |=> cls[2*$past(cc_slot) +: 2] == $past(cls_in)
        && !empty[$past(cc_slot)])
    else $error("class not taken from contents");
  AST_ST_TAGS: assert property (
    go && instr.op == fswc_pkg::OP_STENV
    |=> tag_word_out == fswc_tags($past(empty), $past(cls)))
    else $error("stored tag word not recomputed");
  AST_PUSH_OVF: assert property (
    go && instr.op == fswc_pkg::OP_PUSH && !empty[push_slot]
    |=> top == $past(top) && sw[fswc_pkg::SW_C1] && instr_done)
    else $error("push overflow not detected");
  // only init, push and pop may move the stack top
  AST_TOP_HOLD: assert property (
    go && instr.op != fswc_pkg::OP_INIT && instr.op != fswc_pkg::OP_PUSH
    && instr.op != fswc_pkg::OP_POP |=> top == $past(top))
    else $error("stack top moved on a non-stack instruction");
  // the line follows enabled sticky bits with no extra lag
  AST_IRQ_LVL: assert property (
    irq_q == |(irq_sts & irq_en))
    else $error("interrupt level disagrees with status");
  // zero wait: answer one cycle after setup, then gone
  AST_APB_ANS: assert property (
    apb_setup |=> pready ##1 !pready || (psel && !penable))
    else $error("apb answer timing off");

  COV_OVF:  cover property (ovf ##1 irq_sts[fswc_pkg::IRQ_SF]);
  COV_UNF:  cover property (unf);
  COV_LDST: cover property (go && instr.op == fswc_pkg::OP_LDENV
                            ##[1:20] go && instr.op == fswc_pkg::OP_SAVE);
  COV_IRQ:  cover property (irq);
  COV_WRREG: cover property (go && instr.op == fswc_pkg::OP_WRREG);
endmodule

/* File: core/fswc_pkg.sv */
// fswc_pkg: shared constants and types for the fpu status/tag/control bank
package fswc_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_STATUS  = 8'h00; // status word, read only
  localparam logic [7:0] OFF_CONTROL = 8'h04; // control word, read/write
  localparam logic [7:0] OFF_TAG     = 8'h08; // last stored tag word
  localparam logic [7:0] OFF_IRQ_STS = 8'h0C; // sticky events, read only
  localparam logic [7:0] OFF_IRQ_EN  = 8'h10; // event enables
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14; // write one to clear
  // status word field positions
  localparam int SW_IE  = 0;  // invalid_operation_flag
  localparam int SW_SF  = 6;  // stack_fault_flag
  localparam int SW_C0  = 8;
  localparam int SW_C1  = 9;  // condition_bit_one
  localparam int SW_C2  = 10; // condition_bit_two
  localparam int SW_TOP = 11; // stack top, 3 bits
  localparam int SW_C3  = 14;
  localparam logic [15:0] SW_RST = 16'h0000;
  // control word
  localparam int CW_INF = 12; // infinity closure bit
  localparam logic [15:0] CW_RST = 16'h0000;
  // instruction argument fields
  localparam int ARG_INC = 15; // incomplete flag for remainder/tangent
  // interrupt event positions
  localparam int IRQ_W    = 3;
  localparam int IRQ_SF   = 0; // stack fault
  localparam int IRQ_NUM  = 1; // numeric invalid operation
  localparam int IRQ_PTAN = 2; // tangent incomplete
  // tag encodings
  localparam logic [1:0] TAG_VALID   = 2'h0;
  localparam logic [1:0] TAG_ZERO    = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY   = 2'h3;
  // extended value layout
  localparam int EXP_W  = 15;
  localparam int FRAC_W = 63;

  // instruction codes seen by this bank
  typedef enum logic [3:0] {
    OP_NOP    = 4'h0,
    OP_INIT   = 4'h1, // fpu_initialize_instr
    OP_PREM   = 4'h2, // partial_remainder_instr
    OP_PTAN   = 4'h3, // partial_tangent_instr
    OP_PUSH   = 4'h4,
    OP_POP    = 4'h5,
    OP_READ   = 4'h6,
    OP_LDENV  = 4'h7, // environment_load_instr
    OP_RSTOR  = 4'h8, // state_restore_instr
    OP_STENV  = 4'h9, // environment_store_instr
    OP_SAVE   = 4'hA, // state_save_instr
    OP_WRREG  = 4'hB,
    OP_NUMINV = 4'hC,
    OP_CLREX  = 4'hD
  } fswc_op_t;

  // one instruction request
  typedef struct packed {
    fswc_op_t    op;    // instruction code
    logic [2:0]  idx;   // st(i) index
    logic [15:0] arg;   // tag word, quotient bits, incomplete flag
    logic [79:0] value; // register contents for push/write
  } fswc_instr_t;
endpackage

/* File: core/fswc_classify.sv */
// fswc_classify: derives a register tag class from its contents
`timescale 1ns/10ps
module fswc_classify (
  input  wire logic [79:0] value,
  output logic      [1:0]  cls
);
  logic [fswc_pkg::EXP_W-1:0]  expo; // biased exponent
  logic                        jbit; // explicit integer bit
  logic [fswc_pkg::FRAC_W-1:0] frac; // fraction

  assign expo = value[78:64];
  assign jbit = value[63];
  assign frac = value[62:0];

  // zero, normal valid, or anything else as special
  always_comb begin
    if (expo == '0 && !jbit && frac == '0)
      cls = fswc_pkg::TAG_ZERO;
    else if (expo != '0 && expo != '1 && jbit)
      cls = fswc_pkg::TAG_VALID;
    else
      cls = fswc_pkg::TAG_SPECIAL; // denormal, nan, infinity, unnormal
  end
endmodule

/* File: core/fswc_irq.sv */
// fswc_irq: sticky event bits, enable mask and level interrupt
`timescale 1ns/10ps
module fswc_irq #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] evt,
  input  wire logic         en_we,
  input  wire logic [W-1:0] en_wd,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_wd,
  output logic      [W-1:0] sts,
  output logic      [W-1:0] en,
  output logic              irq
);
  logic [W-1:0] next_sts; // sticky value after this cycle

  // a clear never hides an event of the same cycle
  always_comb begin
    next_sts = clr_we ? (sts & ~clr_wd) : sts;
    next_sts = next_sts | evt;
  end

  // sticky status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sts <= '0;
    else        sts <= next_sts;
  end

  // enable mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)     en <= '0;
    else if (en_we) en <= en_wd;
  end

  // registered level output, in step with the status and enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq <= 1'b0;
    else        irq <= |(next_sts & (en_we ? en_wd : en));
  end
endmodule

/* File: dv/fswc_top_tb_top.sv */
// fswc_top_tb_top: self-checking bench driving apb and instruction ports
`timescale 1ns/10ps
module fswc_top_tb_top;
  logic                  pclk;         // 125 MHz clock
  logic                  presetn;      // async reset, active low
  logic                  psel;         // apb select
  logic                  penable;      // apb access phase
  logic                  pwrite;       // apb direction
  logic [7:0]            paddr;        // apb byte address
  logic [31:0]           pwdata;       // apb write data
  logic [31:0]           prdata;       // apb read data
  logic                  pready;       // apb answer
  logic                  pslverr;      // apb error
  logic                  instr_valid;  // one instruction per cycle high
  fswc_pkg::fswc_instr_t instr;        // instruction request
  logic                  instr_done;   // completion pulse
  logic [15:0]           tag_word_out; // last stored tag word
  logic [15:0]           arith_ctrl;   // control seen by arithmetic
  logic                  irq;          // level interrupt
  logic [31:0]           rd;           // last apb read data
  logic                  err;          // last apb error flag
  int                    n_fail;       // mismatches
  int                    num_checks;   // comparisons made
  // operands: plain zero and a normal one
  localparam logic [79:0] V_ZERO = 80'h0;
  localparam logic [79:0] V_ONE  = 80'h3FFF_8000_0000_0000_0000;

  fswc_top i_fswc_top (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .instr_valid  (instr_valid),
    .instr        (instr),
    .instr_done   (instr_done),
    .tag_word_out (tag_word_out),
    .arith_ctrl   (arith_ctrl),
    .irq          (irq)
  );

  // free running clock, 8 ns period
  always #4 pclk = ~pclk;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single exit point of the run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    // a slave that never answers ends the run
    if (n == 16) begin
      n_fail++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // read a register and compare
  task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask

  // issue one instruction, wait for its completion pulse
  task automatic ins(input fswc_pkg::fswc_op_t op, input logic [2:0] idx,
                     input logic [15:0] arg, input logic [79:0] val);
    int n;
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr       <= {op, idx, arg, val};
    @(posedge pclk);
    instr_valid <= 1'b0;
    // done is a one-cycle pulse, looked at mid-cycle
    for (n = 0; n < 8; n++) begin
      @(negedge pclk);
      if (instr_done === 1'b1) break;
    end
    if (n == 8) begin
      n_fail++;
      summarize();
    end
  endtask

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_valid = 1'b0;
    instr = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset state and an unmapped address
    check({16'h0, tag_word_out}, 32'h0000_FFFF);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0);
    rdchk(fswc_pkg::OFF_CONTROL, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // infinity bit stored but kept away from arithmetic
    apb(1'b1, fswc_pkg::OFF_CONTROL, 32'h0000_137F);
    rdchk(fswc_pkg::OFF_CONTROL, 32'h0000_137F);
    check({16'h0, arith_ctrl}, 32'h0000_037F);
    // status is read only
    apb(1'b1, fswc_pkg::OFF_STATUS, 32'h0000_FFFF);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0);
    ins(fswc_pkg::OP_INIT, 3'h0, 16'h0, V_ZERO);
    rdchk(fswc_pkg::OFF_CONTROL, 32'h0);
    // tangent incomplete flag, set then cleared
    ins(fswc_pkg::OP_PTAN, 3'h0, 16'h8000, V_ZERO);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0000_0400);
    ins(fswc_pkg::OP_PTAN, 3'h0, 16'h0000, V_ZERO);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0);
    // remainder quotient bits, then incomplete and init clear them
    ins(fswc_pkg::OP_PREM, 3'h0, 16'h0007, V_ZERO);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0000_4300);
    ins(fswc_pkg::OP_PREM, 3'h0, 16'h8000, V_ZERO);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0);
    ins(fswc_pkg::OP_PREM, 3'h0, 16'h0007, V_ZERO);
    ins(fswc_pkg::OP_INIT, 3'h0, 16'h0, V_ZERO);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0);
    // underflow on an empty stack, with interrupt enabled
    apb(1'b1, fswc_pkg::OFF_IRQ_CLR, 32'h7);
    apb(1'b1, fswc_pkg::OFF_IRQ_EN, 32'h3);
    ins(fswc_pkg::OP_POP, 3'h0, 16'h0, V_ZERO);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0000_0041);
    rdchk(fswc_pkg::OFF_IRQ_STS, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, fswc_pkg::OFF_IRQ_CLR, 32'h1);
    rdchk(fswc_pkg::OFF_IRQ_STS, 32'h0);
    check({31'h0, irq}, 32'h0);
    ins(fswc_pkg::OP_CLREX, 3'h0, 16'h0, V_ZERO);
    // fill all eight slots: no fault, top wraps to zero
    for (int i = 0; i < 8; i++) begin
      ins(fswc_pkg::OP_PUSH, 3'h0, 16'h0, V_ZERO);
    end
    rdchk(fswc_pkg::OFF_STATUS, 32'h0);
    // ninth push overflows
    ins(fswc_pkg::OP_PUSH, 3'h0, 16'h0, V_ZERO);
    rdchk(fswc_pkg::OFF_STATUS, 32'h0000_0241);
    check({31'h0, irq}, 32'h1);
    // masked event still sticks, line stays low
    apb(1'b1, fswc_pkg::OFF_IRQ_EN, 32'h2);
    apb(1'b1, fswc_pkg::OFF_IRQ_CLR, 32'h7);
    ins(fswc_pkg::OP_CLREX, 3'h0, 16'h0, V_ZERO);
    ins(fswc_pkg::OP_PUSH, 3'h0, 16'h0, V_ZERO);
    rdchk(fswc_pkg::OFF_IRQ_STS, 32'h1);
    check({31'h0, irq}, 32'h0);
    // numeric invalid leaves the stack fault flag clear
    apb(1'b1, fswc_pkg::OFF_IRQ_CLR, 32'h7);
    ins(fswc_pkg::OP_CLREX, 3'h0, 16'h0, V_ZERO);
    ins(fswc_pkg::OP_NUMINV, 3'h0, 16'h0, V_ZERO);
    // overflow direction bit from the last push still stands
    rdchk(fswc_pkg::OFF_STATUS, 32'h0000_0201);
    rdchk(fswc_pkg::OFF_IRQ_STS, 32'h2);
    check({31'h0, irq}, 32'h1);
    // stored tags come from contents: zero in slot 7, normal in 6
    ins(fswc_pkg::OP_INIT, 3'h0, 16'h0, V_ZERO);
    ins(fswc_pkg::OP_PUSH, 3'h0, 16'h0, V_ZERO);
    ins(fswc_pkg::OP_PUSH, 3'h0, 16'h0, V_ONE);
    ins(fswc_pkg::OP_STENV, 3'h0, 16'h0, V_ZERO);
    check({16'h0, tag_word_out}, 32'h0000_4FFF);
    rdchk(fswc_pkg::OFF_TAG, 32'h0000_4FFF);
    // wrong loaded classes are not kept
    ins(fswc_pkg::OP_LDENV, 3'h0, 16'hAFFF, V_ZERO);
    ins(fswc_pkg::OP_SAVE, 3'h0, 16'h0, V_ZERO);
    check({16'h0, tag_word_out}, 32'h0000_4FFF);
    // every tag code on slot 6: only 11 reads as empty
    for (int t = 0; t < 4; t++) begin
      ins(fswc_pkg::OP_LDENV, 3'h0, 16'hCFFF | (16'(t) << 12), V_ZERO);
      ins(fswc_pkg::OP_CLREX, 3'h0, 16'h0, V_ZERO);
      ins(fswc_pkg::OP_READ, 3'h0, 16'h0, V_ZERO);
      rdchk(fswc_pkg::OFF_STATUS, (t == 3) ? 32'h3041 : 32'h3000);
    end
    // restore path: slot 7 nonempty again, slot 6 empty
    ins(fswc_pkg::OP_RSTOR, 3'h0, 16'h3FFF, V_ZERO);
    ins(fswc_pkg::OP_SAVE, 3'h0, 16'h0, V_ZERO);
    check({16'h0, tag_word_out}, 32'h0000_7FFF);
    // written values are classed from contents: slot 7 normal
    ins(fswc_pkg::OP_WRREG, 3'h1, 16'h0, V_ONE);
    ins(fswc_pkg::OP_SAVE, 3'h0, 16'h0, V_ZERO);
    check({16'h0, tag_word_out}, 32'h0000_3FFF);
    // empty slot 6 written with zero becomes nonempty
    ins(fswc_pkg::OP_WRREG, 3'h0, 16'h0, V_ZERO);
    ins(fswc_pkg::OP_SAVE, 3'h0, 16'h0, V_ZERO);
    check({16'h0, tag_word_out}, 32'h0000_1FFF);
    // reset in mid-run clears condition codes
    ins(fswc_pkg::OP_PREM, 3'h0, 16'h0007, V_ZERO);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(fswc_pkg::OFF_STATUS, 32'h0);
    check({16'h0, tag_word_out}, 32'h0000_FFFF);
    summarize();
  end
endmodule
